// *** core/tms_sequencer.sv ***
// transceiver operating-mode sequencer with its small register file
// assumes host inputs synchronous to clk_sys and one-cycle register strobes
//
// Contract
// R01 - reset release: Off to Idle after 10-25 ms
// R02 - Idle: oscillator on, aux clock, port active
// R03 - low-power modes entered only by host command
// R04 - reset held: everything off, outputs high impedance
// R05 - Hibernate: oscillator off, port ignored, wake 7-20 ms
// R06 - Doze: aux clock only if enabled, <=1 MHz
// R07 - Doze: port ignored, wake 300 us plus period
// R08 - receive request: receiver on within 144 us
// R09 - transmit request: transmitter on within 144 us
// R10 - power 0x00BC nominal, 0x00FF maximum
// R11 - host holds reset low at least 250 ns
// R12 - host waits for Idle before any transaction
//
// Chosen here: the plain strobed port and the register addresses.
`include "tms_params.svh"

module tms_sequencer
   import tms_pkg::*;
#(
   parameter int unsigned BOOT_CYC = `TMS_BOOT_US * `TMS_CLK_MHZ,
   parameter int unsigned HIB_WAKE_CYC = `TMS_HIB_WAKE_US * `TMS_CLK_MHZ,
   parameter int unsigned DOZE_WAKE_CYC = `TMS_DOZE_WAKE_US * `TMS_CLK_MHZ,
   parameter int unsigned RADIO_ON_CYC = `TMS_RADIO_ON_US * `TMS_CLK_MHZ,
   parameter int unsigned WAIT_W = 24,
   parameter int unsigned TMR_W = 16
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // register port
   input wire logic [5:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // host wake line
   input wire logic wake_request_in,
   // host interrupt pin, driven high and idle
   output logic irq_n_out,
   output logic irq_oe,
   // auxiliary clock pin
   output logic aux_clock_out,
   output logic aux_clock_oe,
   // mode outputs
   output logic osc_en,
   output logic rx_en,
   output logic tx_en,
   output logic ready,
   output logic [3:0] mode,
   // power amplifier level
   output logic [7:0] pa_level,
   output logic pa_nominal,
   output logic pa_maximum
);

   // state and registers
   tms_state_t state_q, state_d;
   logic [WAIT_W-1:0] wait_q, wait_d;
   logic [2:0] cmd_q;
   logic [TMR_W-1:0] tmr_q, cmp_q;
   logic [15:0] aux_q, pwr_q, div_q, rdata_q;
   logic [7:0] pa_level_q;
   logic tmr_en_q, irq_oe_q, aux_out_q, aux_oe_q;
   logic osc_q, rx_q, tx_q, ready_q, pa_nom_q, pa_max_q;

   // decoded conditions
   logic port_live, wr_ok, rd_ok, cmd_wr, tmr_match, aux_slow, aux_allow;
   logic osc_run;
   logic [2:0] cmd_new;

   // the port only works once the core has a running, settled clock
   assign port_live = (state_q == tms_st_idle) || (state_q == tms_st_rx) ||
                      (state_q == tms_st_tx); // R02 R05 R07
   assign wr_ok = reg_wr && port_live;
   assign rd_ok = reg_rd && port_live;
   assign cmd_wr = wr_ok && (reg_addr == `TMS_ADDR_CTRL);
   assign cmd_new = reg_wdata[`TMS_CTRL_CMD_MSB:`TMS_CTRL_CMD_LSB];
   assign tmr_match = tmr_en_q && (tmr_q == cmp_q);
   assign aux_slow =
      aux_q[`TMS_AUX_SEL_MSB:`TMS_AUX_SEL_LSB] >= `TMS_AUX_SLOW_SEL;
   assign osc_run = (state_q != tms_st_hibernate); // R05

   // taken from the next state so the pin enable moves with mode
   assign aux_allow = (state_d == tms_st_doze) ?
      (aux_q[`TMS_AUX_DOZE_EN] && aux_slow) : // R06
      (state_d inside {tms_st_idle, tms_st_rx_start, tms_st_rx,
                       tms_st_tx_start, tms_st_tx}); // R02

   // mode sequencing
   always_comb
   begin
      state_d = state_q;
      wait_d = wait_q;
      case (state_q)
         tms_st_idle:
            if (cmd_wr)
               case (cmd_new)
                  tms_cmd_hibernate:
                     state_d = tms_st_hibernate; // R03
                  tms_cmd_doze:
                     state_d = tms_st_doze; // R03
                  tms_cmd_receive:
                  begin
                     state_d = tms_st_rx_start; // R08
                     wait_d = WAIT_W'(RADIO_ON_CYC - 1);
                  end
                  tms_cmd_transmit:
                  begin
                     state_d = tms_st_tx_start; // R09
                     wait_d = WAIT_W'(RADIO_ON_CYC - 1);
                  end
                  default:
                     state_d = tms_st_idle;
               endcase
         tms_st_hibernate:
            if (wake_request_in)
            begin
               state_d = tms_st_wake; // R05
               wait_d = WAIT_W'(HIB_WAKE_CYC - 1);
            end
         tms_st_doze:
            if (wake_request_in || tmr_match)
            begin
               state_d = tms_st_wake; // R07
               wait_d = WAIT_W'(DOZE_WAKE_CYC - 1);
            end
         // every timed step counts down, then lands on its target
         tms_st_boot, tms_st_wake, tms_st_rx_start, tms_st_tx_start:
            if (wait_q != '0)
               wait_d = wait_q - 1'b1;
            else if (state_q == tms_st_rx_start)
               state_d = tms_st_rx; // R08
            else if (state_q == tms_st_tx_start)
               state_d = tms_st_tx; // R09
            else
               state_d = tms_st_idle; // R01 R05 R07
         // radio modes only go back through Idle
         tms_st_rx, tms_st_tx:
            if (cmd_wr && (cmd_new == tms_cmd_idle))
               state_d = tms_st_idle;
         default:
         begin
            state_d = tms_st_boot;
            wait_d = WAIT_W'(BOOT_CYC - 1);
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= tms_st_boot;
         wait_q <= WAIT_W'(BOOT_CYC - 1); // R01
      end
      else
      begin
         state_q <= state_d;
         wait_q <= wait_d;
      end
   end

   // control register; contents survive every low-power mode
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmd_q <= 3'h0;
         tmr_en_q <= 1'b0;
      end
      else if (cmd_wr)
      begin
         cmd_q <= cmd_new;
         tmr_en_q <= reg_wdata[`TMS_CTRL_TMR_EN];
      end
   end

   // configuration registers, held while the port is asleep
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aux_q <= `TMS_AUX_RST;
         pwr_q <= `TMS_PWR_RST;
         cmp_q <= TMR_W'(`TMS_CMP_RST);
      end
      else if (wr_ok)
      begin
         case (reg_addr)
            `TMS_ADDR_AUX:
               aux_q <= reg_wdata;
            `TMS_ADDR_PWR:
               pwr_q <= reg_wdata; // R10
            `TMS_ADDR_TMR_CMP:
               cmp_q <= reg_wdata[TMR_W-1:0];
            default:
               aux_q <= aux_q;
         endcase
      end
   end

   // free running timer, frozen with the oscillator; writes restart it
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tmr_q <= '0;
      end
      else if (wr_ok && (reg_addr == `TMS_ADDR_TMR_VAL))
      begin
         tmr_q <= reg_wdata[TMR_W-1:0];
      end
      else if (osc_run)
      begin
         tmr_q <= tmr_q + 1'b1;
      end
   end

   // read port; unmapped and sleeping reads give zero
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_q <= 16'h0000;
      end
      else if (rd_ok)
      begin
         case (reg_addr)
            `TMS_ADDR_CTRL:
               rdata_q <= {7'h00, tmr_en_q, 5'h00, cmd_q};
            `TMS_ADDR_STATUS:
               rdata_q <= {12'h000, state_q};
            `TMS_ADDR_TMR_CMP:
               rdata_q <= 16'(cmp_q);
            `TMS_ADDR_TMR_VAL:
               rdata_q <= 16'(tmr_q);
            `TMS_ADDR_AUX:
               rdata_q <= aux_q;
            `TMS_ADDR_PWR:
               rdata_q <= pwr_q;
            default:
               rdata_q <= 16'h0000;
         endcase
      end
      else
         rdata_q <= 16'h0000;
   end

   // aux clock divider: frequency is clk_sys / 2^(sel+1)
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_q <= 16'h0000;
      end
      else if (osc_run)
      begin
         div_q <= div_q + 16'h0001;
      end
   end

   // pin drivers; all released while reset is low
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aux_out_q <= 1'b0; // R04
         aux_oe_q <= 1'b0; // R04
         irq_oe_q <= 1'b0; // R04
      end
      else
      begin
         aux_out_q <= aux_allow &&
            div_q[aux_q[`TMS_AUX_SEL_MSB:`TMS_AUX_SEL_LSB]]; // R06
         aux_oe_q <= aux_allow; // R02 R06
         irq_oe_q <= 1'b1;
      end
   end

   // mode outputs
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         osc_q <= 1'b0; // R04
         rx_q <= 1'b0;
         tx_q <= 1'b0;
         ready_q <= 1'b0;
      end
      else
      begin
         osc_q <= (state_d != tms_st_hibernate); // R02 R05
         rx_q <= (state_d == tms_st_rx); // R08
         tx_q <= (state_d == tms_st_tx); // R09
         ready_q <= (state_d == tms_st_idle) || (state_d == tms_st_rx) ||
                    (state_d == tms_st_tx);
      end
   end

   // power amplifier setting decode
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pa_level_q <= 8'h00;
         pa_nom_q <= 1'b0;
         pa_max_q <= 1'b0;
      end
      else
      begin
         pa_level_q <= pwr_q[7:0];
         pa_nom_q <= (pwr_q == `TMS_PWR_NOMINAL); // R10
         pa_max_q <= (pwr_q == `TMS_PWR_MAXIMUM); // R10
      end
   end

   assign reg_rdata = rdata_q;
   assign irq_n_out = irq_oe_q;
   assign irq_oe = irq_oe_q;
   assign aux_clock_out = aux_out_q;
   assign aux_clock_oe = aux_oe_q;
   assign osc_en = osc_q;
   assign rx_en = rx_q;
   assign tx_en = tx_q;
   assign ready = ready_q;
   assign mode = state_q;
   assign pa_level = pa_level_q;
   assign pa_nominal = pa_nom_q;
   assign pa_maximum = pa_max_q;

endmodule : tms_sequencer

// *** core/tms_params.svh ***
// constants of the transceiver mode sequencer: offsets, fields, resets, times
// assumes a single 250 MHz core clock and the plain register port
`ifndef TMS_PARAMS_SVH
`define TMS_PARAMS_SVH

`define TMS_CLK_MHZ 250
`define TMS_BOOT_US 10000
`define TMS_HIB_WAKE_US 7000
`define TMS_DOZE_WAKE_US 300
`define TMS_RADIO_ON_US 144

`define TMS_ADDR_CTRL 6'h00
`define TMS_ADDR_STATUS 6'h01
`define TMS_ADDR_TMR_CMP 6'h03
`define TMS_ADDR_TMR_VAL 6'h04
`define TMS_ADDR_AUX 6'h07
`define TMS_ADDR_PWR 6'h0C

`define TMS_CTRL_CMD_LSB 0
`define TMS_CTRL_CMD_MSB 2
`define TMS_CTRL_TMR_EN 8
`define TMS_AUX_SEL_LSB 0
`define TMS_AUX_SEL_MSB 3
`define TMS_AUX_DOZE_EN 9

`define TMS_AUX_SLOW_SEL 4'h7
`define TMS_AUX_RST 16'h000F
`define TMS_PWR_RST 16'h00BC
`define TMS_PWR_NOMINAL 16'h00BC
`define TMS_PWR_MAXIMUM 16'h00FF
`define TMS_CMP_RST 16'hFFFF

`endif

// *** core/tms_pkg.sv ***
// types of the transceiver mode sequencer
// assumes nothing beyond a SystemVerilog compiler
package tms_pkg;

   typedef enum logic [2:0]
   {
      tms_cmd_idle,
      tms_cmd_hibernate,
      tms_cmd_doze,
      tms_cmd_receive,
      tms_cmd_transmit
   } tms_cmd_t;

   typedef enum logic [3:0]
   {
      tms_st_boot,
      tms_st_idle,
      tms_st_hibernate,
      tms_st_doze,
      tms_st_wake,
      tms_st_rx_start,
      tms_st_rx,
      tms_st_tx_start,
      tms_st_tx
   } tms_state_t;

endpackage : tms_pkg

// *** sim/tms_sequencer_sva.sv ***
// port checker of the transceiver mode sequencer
// assumes bind onto tms_sequencer; wait ranges scale with its parameters
module tms_sequencer_sva
#(
   parameter int unsigned BOOT_CYC = 20,
   parameter int unsigned HIB_WAKE_CYC = 15,
   parameter int unsigned DOZE_WAKE_CYC = 10,
   parameter int unsigned RADIO_ON_CYC = 8
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // host side
   input wire logic reg_wr,
   input wire logic wake_request_in,
   // device side
   input wire logic irq_oe,
   input wire logic aux_clock_oe,
   input wire logic osc_en,
   input wire logic rx_en,
   input wire logic tx_en,
   input wire logic ready,
   input wire logic [3:0] mode,
   input wire logic [7:0] pa_level,
   input wire logic pa_nominal,
   input wire logic pa_maximum
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RON_LO = RADIO_ON_CYC - 3;
   localparam int RON_HI = RADIO_ON_CYC;
   localparam int HW_LO = HIB_WAKE_CYC - 4;
   localparam int HW_HI = HIB_WAKE_CYC * 3;
   localparam int DW_HI = DOZE_WAKE_CYC + 2;
   int unsigned boot_q;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   // counts boot edges; a slow boot is as wrong as a fast one
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         boot_q <= 0;
      else if (mode == 4'h0)
         boot_q <= boot_q + 1;
   end

   a_off_hiz:
   assert property (disable iff (1'b0) !rst_n |-> !irq_oe && !aux_clock_oe
      && !osc_en && !ready) else $error("pins driven in reset");
   a_boot_time:
   assert property ($past(mode) == 4'h0 && mode == 4'h1 |->
      boot_q >= BOOT_CYC - 1 && boot_q <= BOOT_CYC * 5 / 2)
      else $error("boot length out of range");
   a_idle_live:
   assert property (mode == 4'h1 |-> ready && osc_en && aux_clock_oe)
      else $error("idle without clock or port");
   a_low_cmd:
   assert property (mode == 4'h1 ##1 (mode == 4'h2 || mode == 4'h3) |->
      $past(reg_wr)) else $error("low power without command");
   a_hib_off:
   assert property (mode == 4'h2 |-> !osc_en && !ready && !aux_clock_oe)
      else $error("hibernate still active");
   a_hib_wake:
   assert property (mode == 4'h2 && wake_request_in |=> (mode == 4'h4) [*2]
      ##[HW_LO:HW_HI] mode == 4'h1) else $error("hibernate wake time");
   a_doze_quiet:
   assert property (mode == 4'h3 |-> !ready && osc_en)
      else $error("doze state wrong");
   a_doze_wake:
   assert property (mode == 4'h3 && wake_request_in |=>
      mode == 4'h4 ##[1:DW_HI] mode == 4'h1) else $error("doze wake time");
   a_rx_on:
   assert property (mode == 4'h1 ##1 mode == 4'h5 |-> !rx_en [*2]
      ##[RON_LO:RON_HI] rx_en && ready) else $error("receiver start time");
   a_tx_on:
   assert property (mode == 4'h1 ##1 mode == 4'h7 |-> !tx_en [*2]
      ##[RON_LO:RON_HI] tx_en && ready) else $error("transmit start time");
   a_pa_flags:
   assert property ((pa_nominal |-> pa_level == 8'hBC)
      and (pa_maximum |-> pa_level == 8'hFF)) else $error("power flag");
endmodule : tms_sequencer_sva

bind tms_sequencer tms_sequencer_sva
#(
   .BOOT_CYC(BOOT_CYC), .HIB_WAKE_CYC(HIB_WAKE_CYC),
   .DOZE_WAKE_CYC(DOZE_WAKE_CYC), .RADIO_ON_CYC(RADIO_ON_CYC)
) u_sva (
   .clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr),
   .wake_request_in(wake_request_in), .irq_oe(irq_oe),
   .aux_clock_oe(aux_clock_oe), .osc_en(osc_en), .rx_en(rx_en),
   .tx_en(tx_en), .ready(ready), .mode(mode), .pa_level(pa_level),
   .pa_nominal(pa_nominal), .pa_maximum(pa_maximum)
);

// *** sim/tms_host_model.sv ***
// host model: reset line, wake line and register strobes
// assumes the one-cycle register port of tms_sequencer
module tms_host_model
(
   // clock
   input wire logic clk_sys,
   // host outputs
   output logic rst_n,
   output logic [5:0] reg_addr,
   output logic [15:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   output logic wake_request_in,
   // device answer
   input wire logic [15:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   // non-blocking so the flops already wait on the reset edge
   initial
   begin
      rst_n <= 1'b0;
      reg_addr <= 6'h00;
      reg_wdata <= 16'h0000;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      wake_request_in <= 1'b0;
   end

   // short pulses may go unseen, so never below 63 edges
   task automatic hold_reset(input int n);
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (n) @(posedge clk_sys);
      rst_n <= 1'b1;
   endtask : hold_reset

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [5:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd

   task automatic wake(input logic v);
      @(posedge clk_sys);
      wake_request_in <= v;
   endtask : wake
endmodule : tms_host_model

// *** sim/transceiver_mode_sequencer_tb.sv ***
// self-checking bench of the transceiver mode sequencer
// assumes shortened wait parameters and the host model beside the block
`include "tms_params.svh"
`define CHK(a, e) \
   begin \
      total_checks++; \
      if ((a) !== (e)) \
      begin \
         failures++; \
         $display("unexpected at %0t got %0h exp %0h", $time, (a), (e)); \
      end \
   end

module transceiver_mode_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rst_n;
   logic [5:0] reg_addr;
   logic [15:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic wake_request_in;
   logic [15:0] reg_rdata;
   logic irq_n_out;
   logic irq_oe;
   logic aux_clock_out;
   logic aux_clock_oe;
   logic osc_en;
   logic rx_en;
   logic tx_en;
   logic ready;
   logic [3:0] mode;
   logic [7:0] pa_level;
   logic pa_nominal;
   logic pa_maximum;
   logic [15:0] rdv;
   int failures = 0;
   int total_checks = 0;

   initial
   begin
      forever #2 clk_sys = ~clk_sys;
   end

   tms_host_model h (.clk_sys(clk_sys), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .wake_request_in(wake_request_in),
      .reg_rdata(reg_rdata));

   tms_sequencer #(.BOOT_CYC(20), .HIB_WAKE_CYC(15), .DOZE_WAKE_CYC(10),
      .RADIO_ON_CYC(8)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .wake_request_in(wake_request_in), .irq_n_out(irq_n_out),
      .irq_oe(irq_oe), .aux_clock_out(aux_clock_out),
      .aux_clock_oe(aux_clock_oe), .osc_en(osc_en), .rx_en(rx_en),
      .tx_en(tx_en), .ready(ready), .mode(mode), .pa_level(pa_level),
      .pa_nominal(pa_nominal), .pa_maximum(pa_maximum));

   task automatic test_done;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : test_done

   // bounded wait; the caller judges the mode reached
   task automatic wait_mode(input logic [3:0] m);
      int n;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      while (mode !== m && n < 100);
   endtask : wait_mode

   task automatic t_boot;
      fork
         h.hold_reset(70);
         begin
            repeat (5) @(posedge clk_sys);
            #1;
            `CHK({irq_oe, aux_clock_oe, osc_en, ready, rx_en}, 5'h00)
         end
      join
      @(posedge clk_sys);
      #1;
      `CHK({ready, irq_oe, irq_n_out, osc_en, mode}, 8'h70)
      wait_mode(4'h1);
      `CHK({ready, osc_en, aux_clock_oe, mode}, 7'h71)
      h.rd(`TMS_ADDR_PWR, rdv);
      `CHK({rdv, pa_nominal}, {`TMS_PWR_NOMINAL, 1'b1})
      h.rd(6'h3F, rdv);
      `CHK(rdv, 16'h0000)
      h.rd(`TMS_ADDR_STATUS, rdv);
      `CHK(rdv, 16'h0001)
   endtask : t_boot

   task automatic t_power;
      logic v;
      h.wr(`TMS_ADDR_PWR, `TMS_PWR_MAXIMUM);
      @(posedge clk_sys);
      #1;
      `CHK({pa_maximum, pa_nominal, pa_level}, 10'h2FF)
      h.rd(`TMS_ADDR_PWR, rdv);
      `CHK(rdv, 16'h00FF)
      // fastest aux setting flips the pin every cycle in Idle
      h.wr(`TMS_ADDR_AUX, 16'h0000);
      @(posedge clk_sys);
      #1;
      v = aux_clock_out;
      @(posedge clk_sys);
      #1;
      `CHK(aux_clock_out, !v)
   endtask : t_power

   task automatic t_radio(input logic [15:0] c);
      h.wr(`TMS_ADDR_CTRL, c);
      #1;
      `CHK({ready, rx_en, tx_en}, 3'h0)
      wait_mode({c[2:0], 1'b0});
      `CHK({rx_en, tx_en, ready}, (c == 16'h3) ? 3'h5 : 3'h3)
      h.wr(`TMS_ADDR_CTRL, 16'h0000);
      wait_mode(4'h1);
      `CHK({mode, rx_en, tx_en}, 6'h04)
   endtask : t_radio

   task automatic t_hib;
      h.wr(`TMS_ADDR_CTRL, 16'h0001);
      @(posedge clk_sys);
      #1;
      `CHK({mode, osc_en, ready, aux_clock_oe}, 7'h10)
      // a write while asleep must be lost
      h.wr(`TMS_ADDR_PWR, 16'h0055);
      h.wake(1'b1);
      wait_mode(4'h1);
      h.wake(1'b0);
      #1;
      `CHK({mode, osc_en}, 5'h03)
      h.rd(`TMS_ADDR_PWR, rdv);
      `CHK(rdv, 16'h00FF)
   endtask : t_hib

   task automatic t_doze(input logic [15:0] aux, input logic [15:0] c,
      input logic w, input logic oe);
      h.wr(`TMS_ADDR_AUX, aux);
      h.wr(`TMS_ADDR_TMR_VAL, 16'h0000);
      h.wr(`TMS_ADDR_TMR_CMP, 16'h0030);
      h.wr(`TMS_ADDR_CTRL, c);
      @(posedge clk_sys);
      #1;
      `CHK({mode, aux_clock_oe, osc_en, ready}, {4'h3, oe, 2'h2})
      if (w)
         h.wake(1'b1);
      wait_mode(4'h1);
      h.wake(1'b0);
      #1;
      `CHK({mode, ready}, 5'h03)
   endtask : t_doze

   initial
   begin
      t_boot();
      t_power();
      t_radio(16'h0003);
      t_radio(16'h0004);
      t_hib();
      // 1.95 MHz stays off, 0.98 MHz may run
      t_doze(16'h0206, 16'h0002, 1'b1, 1'b0);
      t_doze(16'h0207, 16'h0102, 1'b0, 1'b1);
      t_boot();
      test_done();
   end

   initial
   begin
      #40000;
      failures++;
      test_done();
   end
endmodule : transceiver_mode_sequencer_tb
